// file: ccarr_top.sv
`timescale 1ns/1ns
// How it works
// - capture copies full 16-bit counter to module
// - capture on rising, falling or both edges
// - interrupt only when flag and enable set
// - hardware sets flag, software clears it
// - new capture overwrites unread capture value
// - comparator plus match enable signal equality event
// - low write suspends comparator, high write resumes
// - toggle pin on every match when enabled
// - unchanged compare toggles again after wrap
// - pwm low below compare byte, else high
// - pwm entered by width and comparator enables
// - pwm duty byte reloads at low-byte wrap
// - all modules share one counter
// - only module four may be watchdog
// - watchdog match raises internal reset and also sets its event flag
// - counter mode bit six enables watchdog reset
// - watchdog toggle enable optional
module ccarr_top import ccarr_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_MOD-1:0] modulePinIn,
    output logic [NUM_MOD-1:0] modulePinOut,
    output logic interruptRequest,
    output logic watchdogReset
);
    ccarr_top_t st_reg;
    ccarr_top_t st_next;
    logic access;
    logic doWrite;
    logic [7:0] regIdx;
    logic addrMapped;
    logic [7:0] wbyte;
    logic [7:0] readByte;
    logic [NUM_MOD-1:0] eventPulse;
    logic [NUM_MOD-1:0] matchPulse;
    logic [NUM_MOD-1:0] wrModeSel;
    logic [NUM_MOD-1:0] wrLowSel;
    logic [NUM_MOD-1:0] wrHighSel;
    logic [7:0] cmpLow [NUM_MOD];
    logic [7:0] cmpHigh [NUM_MOD];
    logic [NUM_MOD-1:0] eventIrqEnable;
    logic watchdogMatch;

    assign access = psel && penable;
    assign doWrite = access && pwrite && addrMapped;
    assign regIdx = paddr[9:2];
    assign wbyte = pwdata[7:0];

    always_comb begin
        addrMapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) && (
            regIdx == IDX_CTRL || regIdx == IDX_CMODE || regIdx == IDX_CNTLO
            || regIdx == IDX_CNTHI
            || (regIdx >= IDX_MODE0 && regIdx < IDX_MODE0 + 8'(NUM_MOD))
            || (regIdx >= IDX_CMPLO0 && regIdx < IDX_CMPLO0 + 8'(NUM_MOD))
            || (regIdx >= IDX_CMPHI0 && regIdx < IDX_CMPHI0 + 8'(NUM_MOD)));
    end

    for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
        assign wrModeSel[m] = doWrite && regIdx == IDX_MODE0 + 8'(m);
        assign wrLowSel[m] = doWrite && regIdx == IDX_CMPLO0 + 8'(m);
        assign wrHighSel[m] = doWrite && regIdx == IDX_CMPHI0 + 8'(m);
        assign eventIrqEnable[m] = st_reg.moduleMode[m].eventInterruptEnable;
        // Every module runs from the one shared counter.
        ccarr_channel u_chan (
            .clk(clk),
            .rst_b(rst_b),
            .counterValue(st_reg.counter),
            .counterNew(st_reg.counterNew),
            .modulePinIn(modulePinIn[m]),
            .mode(st_reg.moduleMode[m]),
            .writeLow(wrLowSel[m]),
            .writeHigh(wrHighSel[m]),
            .writeData(wbyte),
            .modulePinOut(modulePinOut[m]),
            .compareValueLow(cmpLow[m]),
            .compareValueHigh(cmpHigh[m]),
            .eventPulse(eventPulse[m]),
            .matchPulse(matchPulse[m])
        );
    end

    // Only module four can pull the internal reset; other modes stay usable.
    assign watchdogMatch = matchPulse[WD_MOD] && st_reg.moduleMode[WD_MOD].matchEventEnable
        && st_reg.counterMode[CMODE_WATCHDOG_RESET_ENABLE_BIT];

    always_comb begin
        readByte = RESET_BYTE;
        for (int m = 0; m < NUM_MOD; m++) begin
            if (regIdx == IDX_MODE0 + 8'(m)) begin
                readByte = st_reg.moduleMode[m];
            end
            if (regIdx == IDX_CMPLO0 + 8'(m)) begin
                readByte = cmpLow[m];
            end
            if (regIdx == IDX_CMPHI0 + 8'(m)) begin
                readByte = cmpHigh[m];
            end
        end
        if (regIdx == IDX_CTRL) begin
            readByte = {st_reg.overflow, st_reg.run, 1'b0, st_reg.moduleEventFlag};
        end
        if (regIdx == IDX_CMODE) begin
            readByte = st_reg.counterMode;
        end
        if (regIdx == IDX_CNTLO) begin
            readByte = st_reg.counter[7:0];
        end
        if (regIdx == IDX_CNTHI) begin
            readByte = st_reg.counter[15:8];
        end
    end

    assign prdata = (access && !pwrite && addrMapped) ? {24'h000000, readByte} : 32'h00000000;
    assign pready = 1'b1;
    assign pslverr = access && !addrMapped;

    always_comb begin
        st_next = st_reg;
        st_next.counterNew = 1'b0;
        st_next.watchdogReset = watchdogMatch;
        if (st_reg.run) begin
            st_next.counter = st_reg.counter + 16'h0001;
            st_next.counterNew = 1'b1;
            if (st_reg.counter == 16'hffff) begin
                st_next.overflow = 1'b1;
            end
        end
        if (doWrite && regIdx == IDX_CNTLO) begin
            st_next.counter[7:0] = wbyte;
            st_next.counterNew = 1'b1;
        end
        if (doWrite && regIdx == IDX_CNTHI) begin
            st_next.counter[15:8] = wbyte;
            st_next.counterNew = 1'b1;
        end
        if (doWrite && regIdx == IDX_CTRL) begin
            st_next.run = wbyte[CTRL_RUN_BIT];
            st_next.overflow = wbyte[CTRL_OVF_BIT] || (st_next.overflow && !st_reg.overflow);
            st_next.moduleEventFlag = wbyte[NUM_MOD-1:0];
        end
        if (doWrite && regIdx == IDX_CMODE) begin
            st_next.counterMode = wbyte;
        end
        for (int m = 0; m < NUM_MOD; m++) begin
            if (wrModeSel[m]) begin
                st_next.moduleMode[m] = wbyte;
            end
        end
        // Hardware sets win over a software clear in the same cycle.
        st_next.moduleEventFlag = st_next.moduleEventFlag | eventPulse;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign interruptRequest = |(st_reg.moduleEventFlag & eventIrqEnable);
    assign watchdogReset = st_reg.watchdogReset;

    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        eventPulse[0] && eventIrqEnable[0] && !wrModeSel[0] |=> interruptRequest)
        else $error("interrupt request disagrees with flags");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        eventPulse[0] |=> st_reg.moduleEventFlag[0])
        else $error("event did not set flag");
    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.moduleEventFlag[1] && !(doWrite && regIdx == IDX_CTRL)
        |=> st_reg.moduleEventFlag[1])
        else $error("flag cleared without software");
    wd_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
        matchPulse[WD_MOD] && st_reg.moduleMode[WD_MOD].matchEventEnable
        && st_reg.counterMode[CMODE_WATCHDOG_RESET_ENABLE_BIT] |=> watchdogReset)
        else $error("watchdog match gave no reset");
    wd_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        !st_reg.counterMode[CMODE_WATCHDOG_RESET_ENABLE_BIT] |=> !watchdogReset)
        else $error("watchdog reset while disabled");
    count_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.run && !(doWrite && (regIdx == IDX_CNTLO || regIdx == IDX_CNTHI))
        |=> st_reg.counter == $past(st_reg.counter) + 16'h0001)
        else $error("shared counter did not advance");
    match_once_a: assert property (@(posedge clk) disable iff (!rst_b)
        !st_reg.counterNew |-> matchPulse == '0)
        else $error("match without new counter value");
    unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_b)
        access && !addrMapped |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    cover_wd: cover property (@(posedge clk) disable iff (!rst_b) watchdogReset);
    cover_irq: cover property (@(posedge clk) disable iff (!rst_b) interruptRequest);
    cover_ovf: cover property (@(posedge clk) disable iff (!rst_b) $rose(st_reg.overflow));
endmodule

// file: ccarr_pkg.sv
package ccarr_pkg;

    localparam int NUM_MOD = 5;
    localparam int WD_MOD = 4;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CTRL = 8'hd8;
    localparam logic [7:0] IDX_CMODE = 8'hd9;
    localparam logic [7:0] IDX_MODE0 = 8'hda;
    localparam logic [7:0] IDX_CNTLO = 8'he9;
    localparam logic [7:0] IDX_CMPLO0 = 8'hea;
    localparam logic [7:0] IDX_CNTHI = 8'hf9;
    localparam logic [7:0] IDX_CMPHI0 = 8'hfa;

    // Control register fields.
    localparam int CTRL_OVF_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    // Counter mode register field.
    localparam int CMODE_WATCHDOG_RESET_ENABLE_BIT = 6;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] LOW_BYTE_MAX = 8'hff;

    typedef struct packed {
        logic reserved;
        logic comparatorEnable;
        logic risingCaptureEnable;
        logic fallingCaptureEnable;
        logic matchEventEnable;
        logic toggleEnable;
        logic widthModEnable;
        logic eventInterruptEnable;
    } ccarr_mode_t;

    typedef struct packed {
        logic [7:0] compareValueLow;
        logic [7:0] compareValueHigh;
        logic suspended;
        logic pinPrev;
        logic pinOut;
        logic eventPulse;
    } ccarr_chan_t;

    typedef struct packed {
        logic [15:0] counter;
        logic counterNew;
        logic run;
        logic overflow;
        logic [NUM_MOD-1:0] moduleEventFlag;
        logic [7:0] counterMode;
        ccarr_mode_t [NUM_MOD-1:0] moduleMode;
        logic watchdogReset;
    } ccarr_top_t;

endpackage

// file: ccarr_channel.sv
`timescale 1ns/1ns
module ccarr_channel import ccarr_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] counterValue,
    input wire logic counterNew,
    input wire logic modulePinIn,
    input wire ccarr_mode_t mode,
    input wire logic writeLow,
    input wire logic writeHigh,
    input wire logic [7:0] writeData,
    output logic modulePinOut,
    output logic [7:0] compareValueLow,
    output logic [7:0] compareValueHigh,
    output logic eventPulse,
    output logic matchPulse
);
    ccarr_chan_t st_reg;
    ccarr_chan_t st_next;
    logic riseSeen;
    logic fallSeen;
    logic capture;
    logic pwmMode;

    assign pwmMode = mode.widthModEnable && mode.comparatorEnable;
    assign riseSeen = modulePinIn && !st_reg.pinPrev && mode.risingCaptureEnable;
    assign fallSeen = !modulePinIn && st_reg.pinPrev && mode.fallingCaptureEnable;
    assign capture = riseSeen || fallSeen;
    // A match counts once per new counter value, never while the count is held.
    assign matchPulse = counterNew && mode.comparatorEnable && !st_reg.suspended && !pwmMode
        && counterValue == {st_reg.compareValueHigh, st_reg.compareValueLow};

    always_comb begin
        st_next = st_reg;
        st_next.pinPrev = modulePinIn;
        st_next.eventPulse = capture || (matchPulse && mode.matchEventEnable);
        if (writeLow) begin
            st_next.compareValueLow = writeData;
            st_next.suspended = 1'b1;
        end
        if (writeHigh) begin
            st_next.compareValueHigh = writeData;
            st_next.suspended = 1'b0;
        end
        if (capture) begin
            st_next.compareValueLow = counterValue[7:0];
            st_next.compareValueHigh = counterValue[15:8];
        end
        if (pwmMode) begin
            st_next.pinOut = counterValue[7:0] >= st_reg.compareValueLow;
            if (counterNew && counterValue[7:0] == RESET_BYTE) begin
                st_next.compareValueLow = st_reg.compareValueHigh;
            end
        end else if (matchPulse && mode.matchEventEnable && mode.toggleEnable) begin
            st_next.pinOut = !st_reg.pinOut;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign modulePinOut = st_reg.pinOut;
    assign compareValueLow = st_reg.compareValueLow;
    assign compareValueHigh = st_reg.compareValueHigh;
    assign eventPulse = st_reg.eventPulse;

    capture_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        capture |=> {compareValueHigh, compareValueLow} == $past(counterValue))
        else $error("capture did not load the counter");
    toggle_match_a: assert property (@(posedge clk) disable iff (!rst_b)
        (matchPulse && mode.matchEventEnable && mode.toggleEnable && !pwmMode)
        |=> modulePinOut != $past(modulePinOut))
        else $error("pin did not toggle on match");
    suspend_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        (writeLow && !writeHigh) |=> !matchPulse)
        else $error("comparator matched after low byte write");
    pwm_level_a: assert property (@(posedge clk) disable iff (!rst_b)
        pwmMode && $stable(pwmMode) && !counterNew && $stable(counterValue)
        |=> modulePinOut == ($past(counterValue[7:0]) >= $past(compareValueLow)))
        else $error("pwm level wrong");
    cover_capture: cover property (@(posedge clk) disable iff (!rst_b) capture);
    cover_toggle: cover property (@(posedge clk) disable iff (!rst_b)
        matchPulse && mode.toggleEnable);
endmodule

// file: ccarr_pin_model.sv
`timescale 1ns/1ns
module ccarr_pin_model import ccarr_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_MOD-1:0] levelCmd,
    output logic [NUM_MOD-1:0] modulePinIn
);
    // The pins move only at clock edges, since the block treats them as synchronous inputs.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            modulePinIn <= '0;
        end else begin
            modulePinIn <= levelCmd;
        end
    end
endmodule

// file: ccarr_top_test.sv
`timescale 1ns/1ns
module ccarr_top_test import ccarr_pkg::*;;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, interruptRequest, watchdogReset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NUM_MOD-1:0] modulePinIn, modulePinOut, pinCmd;
    logic lastPin;
    int errorCnt, testsRun, togCnt, wdCnt, seed, m;

    ccarr_top dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modulePinIn(modulePinIn), .modulePinOut(modulePinOut),
        .interruptRequest(interruptRequest), .watchdogReset(watchdogReset));
    ccarr_pin_model pin_u (.clk(clk), .rst_b(rst_b), .levelCmd(pinCmd), .modulePinIn(modulePinIn));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Toggles and reset pulses are counted all the time; scenarios compare snapshots.
    always @(posedge clk) begin
        if (modulePinOut[m] !== lastPin) begin
            togCnt <= togCnt + 1;
        end
        lastPin <= modulePinOut[m];
        if (watchdogReset === 1'b1) begin
            wdCnt <= wdCnt + 1;
        end
    end

    task automatic stopTest();
        if (errorCnt == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] ix(input logic [7:0] b, input int k);
        return b + 8'(k);
    endfunction

    function automatic logic pwmLevel(input logic [7:0] cnt, input logic [7:0] duty);
        return cnt >= duty;
    endfunction

    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
            output logic [31:0] r, output logic e);
        int k;
        logic rdy;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // The answer is read while it is settled, half a cycle before the edge that ends it.
        do begin
            @(negedge clk);
            rdy = pready;
            r = prdata;
            e = pslverr;
            k++;
            @(posedge clk);
        end while (rdy !== 1'b1 && k < 20);
        if (rdy !== 1'b1) begin
            errorCnt++;
            stopTest();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps a following setup from reassigning psel in this time step.
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask

    task automatic rdChk(input logic [7:0] i, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, i, 8'h00, r, e);
        chk(r, {24'h0, exp});
    endtask

    task automatic setCnt(input logic [15:0] v);
        wr(IDX_CNTLO, v[7:0]);
        wr(IDX_CNTHI, v[15:8]);
    endtask

    task automatic setCmp(input logic [15:0] v);
        wr(ix(IDX_CMPLO0, m), v[7:0]);
        wr(ix(IDX_CMPHI0, m), v[15:8]);
    endtask

    task automatic runCount(input int n, input int expTog, input int expWd);
        int t0, w0;
        t0 = togCnt;
        w0 = wdCnt;
        wr(IDX_CTRL, 8'h40);
        repeat (n) @(posedge clk);
        wr(IDX_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        chk(togCnt - t0, expTog);
        chk(wdCnt - w0, expWd);
    endtask

    initial begin
        #400000;
        errorCnt++;
        stopTest();
    end

    initial begin
        logic [31:0] r;
        logic e;
        logic [15:0] v, w;
        int i;
        seed = 28931;
        {rst_b, psel, penable, pwrite, lastPin} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pinCmd = '0;
        m = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (i = 0; i < NUM_MOD; i++) begin
            rdChk(ix(IDX_MODE0, i), RESET_BYTE);
            rdChk(ix(IDX_CMPLO0, i), RESET_BYTE);
            rdChk(ix(IDX_CMPHI0, i), RESET_BYTE);
        end
        rdChk(IDX_CTRL, RESET_BYTE);
        rdChk(IDX_CMODE, RESET_BYTE);
        apb(1'b0, 8'h00, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        // Capture with the counter stopped, so the captured value is known exactly.
        m = {$random(seed)} % NUM_MOD;
        v = $random(seed);
        setCnt(v);
        wr(ix(IDX_MODE0, m), 8'h20);
        pinCmd[m] <= 1'b1;
        repeat (6) @(posedge clk);
        rdChk(ix(IDX_CMPLO0, m), v[7:0]);
        rdChk(ix(IDX_CMPHI0, m), v[15:8]);
        rdChk(IDX_CTRL, 8'h01 << m);
        chk({31'h0, interruptRequest}, 32'h0);
        wr(ix(IDX_MODE0, m), 8'h21);
        repeat (2) @(posedge clk);
        chk({31'h0, interruptRequest}, 32'h1);
        w = $random(seed);
        setCnt(w);
        pinCmd[m] <= 1'b0;
        repeat (6) @(posedge clk);
        rdChk(ix(IDX_CMPHI0, m), v[15:8]);
        rdChk(IDX_CTRL, 8'h01 << m);
        wr(ix(IDX_MODE0, m), 8'h31);
        pinCmd[m] <= 1'b1;
        repeat (6) @(posedge clk);
        v = $random(seed);
        setCnt(v);
        pinCmd[m] <= 1'b0;
        repeat (6) @(posedge clk);
        rdChk(ix(IDX_CMPLO0, m), v[7:0]);
        rdChk(ix(IDX_CMPHI0, m), v[15:8]);
        wr(IDX_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        chk({31'h0, interruptRequest}, 32'h0);
        wr(ix(IDX_MODE0, m), 8'h00);
        // High-speed output across a full counter wrap, then a suspended comparator.
        m = {$random(seed)} % NUM_MOD;
        wr(ix(IDX_MODE0, m), 8'h4c);
        setCmp(16'h0108);
        setCnt(16'h0100);
        runCount(65556, 2, 0);
        setCnt(16'h0100);
        wr(ix(IDX_CMPLO0, m), 8'h08);
        runCount(20, 0, 0);
        wr(ix(IDX_CMPHI0, m), 8'h01);
        setCnt(16'h0100);
        runCount(20, 1, 0);
        wr(ix(IDX_MODE0, m), 8'h00);
        // Pulse width: duty byte reaches the compare low byte only at the low-byte wrap.
        m = {$random(seed)} % NUM_MOD;
        v = $random(seed);
        setCnt(16'h00f8);
        wr(ix(IDX_MODE0, m), 8'h42);
        wr(ix(IDX_CMPLO0, m), v[7:0]);
        wr(ix(IDX_CMPHI0, m), v[15:8]);
        rdChk(ix(IDX_CMPLO0, m), v[7:0]);
        wr(IDX_CTRL, 8'h40);
        repeat (16) @(posedge clk);
        wr(IDX_CTRL, 8'h00);
        rdChk(ix(IDX_CMPLO0, m), v[15:8]);
        for (i = 0; i < 6; i++) begin
            wr(IDX_CTRL, 8'h40);
            repeat (1 + {$random(seed)} % 300) @(posedge clk);
            wr(IDX_CTRL, 8'h00);
            apb(1'b0, IDX_CNTLO, 8'h00, r, e);
            chk({31'h0, modulePinOut[m]}, {31'h0, pwmLevel(r[7:0], v[15:8])});
        end
        wr(ix(IDX_MODE0, m), 8'h00);
        // Watchdog on module 4 with toggling, then with the reset disabled, then elsewhere.
        m = WD_MOD;
        wr(ix(IDX_MODE0, m), 8'h4c);
        wr(IDX_CMODE, 8'h40);
        setCmp(16'h0108);
        setCnt(16'h0100);
        runCount(20, 1, 1);
        setCmp(16'h8000);
        setCnt(16'h0100);
        runCount(20, 0, 0);
        setCmp(16'h0108);
        wr(IDX_CMODE, 8'h00);
        setCnt(16'h0100);
        runCount(20, 1, 0);
        wr(ix(IDX_MODE0, m), 8'h00);
        m = 0;
        wr(ix(IDX_MODE0, m), 8'h4c);
        setCmp(16'h0108);
        wr(IDX_CMODE, 8'h40);
        setCnt(16'h0100);
        runCount(20, 1, 0);
        stopTest();
    end
endmodule
